// file: verilog/bank_cmd_pkg.sv
// Shared constants and types for the bank command state logic
package bank_cmd_pkg;
  localparam int NUM_BANKS         = 4;
  localparam int ROW_W             = 13;
  localparam int COL_W             = 10;
  localparam int CLK_PERIOD_PS     = 8000;
  // Timing figures in picoseconds, plain defaults
  localparam int CLOSE_PERIOD_PS      = 20000;
  localparam int ROW_TO_COL_DELAY_PS  = 20000;
  localparam int ROW_CYCLE_TIME_PS    = 65000;
  localparam int MODE_SET_RECOVERY_PS = 16000;
  localparam int BURST_LEN            = 4;
  // Least times round up
  localparam int CLOSE_CYC  = (CLOSE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RCD_CYC    = (ROW_TO_COL_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RC_CYC     = (ROW_CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MRS_CYC    = (MODE_SET_RECOVERY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RECOV_CYC  = 2;
  localparam int AUTO_CLOSE_BIT = 10;
  localparam logic [1:0] MODE_BASE_SEL = 2'h0;
  localparam logic [1:0] MODE_EXT_SEL  = 2'h1;
  localparam logic [ROW_W-1:0] MODE_RESET = 13'h0000;

  typedef enum logic [3:0] {
    CMD_DESELECT, CMD_NOP, CMD_STOP, CMD_READ, CMD_WRITE,
    CMD_ROW_OPEN, CMD_CLOSE, CMD_REFRESH, CMD_MODE_SET
  } cmd_t;

  typedef enum logic [3:0] {
    B_IDLE, B_OPENING, B_ACTIVE, B_READ, B_READ_AC, B_WRITE, B_WRITE_AC,
    B_RECOVER, B_CLOSING
  } bank_st_t;

  typedef enum logic [2:0] {
    G_NORMAL, G_REFRESHING, G_MODE_SETTING, G_SELF_REFRESH, G_SR_EXIT,
    G_POWER_DOWN, G_SUSPEND
  } glob_st_t;
endpackage

// file: verilog/ddr_bank_command_fsm.sv
// Per-bank command state tracking with clock-enable power modes
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Mode set bank lines 0 pick base, 1 pick extended; address is op-code.
// - Row open on idle bank starts opening it and latches its row.
// - Read on active bank starts burst, latches column, auto-close from bit.
// - Write on active bank starts burst, latches column, auto-close from bit.
// - Deselect and no-op let a running burst finish unchanged.
// - Read during plain read burst restarts burst with new column.
// - Read during plain write burst ends write and starts read.
// - Write during plain write burst restarts write with new column.
// - Closing bank ignores no-op and close; becomes idle after close period.
// - Opening bank becomes active after row-to-column delay; others illegal.
// - During refresh only no-op or deselect accepted; idle after row cycle time.
// - After mode set only no-op or deselect accepted until recovery period ends.
// - Command reactions apply only with clock enable high previous and present.
// - Legality is judged against the bank selected by the bank lines.
// - Close to idle or closing bank has no effect on that bank.
// - Self refresh held by low enable; exit with no-op, idle after row cycle.
// - All idle, enable low with refresh enters self refresh, with no-op or deselect power down.
// - With a bank not idle, enable low suspends clock next cycle; high resumes next cycle.
module ddr_bank_command_fsm
  import bank_cmd_pkg::*;
#(
  parameter int BANKS = NUM_BANKS,
  parameter int BURST = BURST_LEN
) (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               reset_n,
  // Command pins, already in the memory clock domain
  input  wire logic               clkEn,
  input  wire logic               chipSel_n,
  input  wire logic               rowStrobe_n,
  input  wire logic               colStrobe_n,
  input  wire logic               writeEn_n,
  input  wire logic [1:0]         bankSel,
  input  wire logic [ROW_W-1:0]   addr,
  // Observed state
  output logic [4*BANKS-1:0]      bankState,
  output logic [ROW_W*BANKS-1:0]  row_addr,
  output logic [COL_W*BANKS-1:0]  col_addr,
  output logic [ROW_W-1:0]        baseMode,
  output logic [ROW_W-1:0]        extMode,
  output logic [2:0]              globalState,
  output logic                    illegalCmd,
  // Event stream through a two-entry buffer
  output logic                    evtValid,
  input  wire logic               evtReady,
  output logic [7:0]              evtData,
  output logic                    evtOverrun
);
  bank_st_t st [BANKS];
  logic [7:0] cnt [BANKS];
  glob_st_t gst;
  logic [7:0] gcnt;
  logic clkEnPrev;
  cmd_t cmd;
  logic autoClose;
  logic allIdle;
  logic cmdPhase;
  logic bankBad;
  logic next_illegal;

  // Chip select high turns anything into a deselect
  always_comb begin
    unique casez ({chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n})
      4'b1???: cmd = CMD_DESELECT;
      4'b0111: cmd = CMD_NOP;
      4'b0110: cmd = CMD_STOP;
      4'b0101: cmd = CMD_READ;
      4'b0100: cmd = CMD_WRITE;
      4'b0011: cmd = CMD_ROW_OPEN;
      4'b0010: cmd = CMD_CLOSE;
      4'b0001: cmd = CMD_REFRESH;
      default: cmd = CMD_MODE_SET;
    endcase
  end
  assign autoClose = addr[AUTO_CLOSE_BIT];
  assign cmdPhase  = clkEnPrev && clkEn && gst == G_NORMAL;

  always_comb begin
    allIdle = 1'b1;
    for (int i = 0; i < BANKS; i++) begin
      if (st[i] != B_IDLE) begin
        allIdle = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      clkEnPrev <= 1'b1;
    end else begin
      clkEnPrev <= clkEn;
    end
  end

  // Legality of the selected bank only
  always_comb begin
    bankBad = 1'b0;
    unique case (st[bankSel])
      B_IDLE:     bankBad = cmd == CMD_STOP || cmd == CMD_READ || cmd == CMD_WRITE;
      B_ACTIVE:   bankBad = cmd == CMD_STOP || cmd == CMD_ROW_OPEN;
      B_READ:     bankBad = cmd == CMD_WRITE || cmd == CMD_ROW_OPEN;
      B_WRITE:    bankBad = cmd == CMD_STOP || cmd == CMD_ROW_OPEN;
      B_READ_AC, B_WRITE_AC: bankBad = cmd inside {CMD_STOP, CMD_READ, CMD_WRITE, CMD_ROW_OPEN, CMD_CLOSE};
      B_CLOSING:  bankBad = cmd inside {CMD_STOP, CMD_READ, CMD_WRITE, CMD_ROW_OPEN};
      B_OPENING, B_RECOVER: bankBad = cmd inside {CMD_STOP, CMD_READ, CMD_WRITE, CMD_ROW_OPEN, CMD_CLOSE};
    endcase
    next_illegal = 1'b0;
    if (gst == G_REFRESHING || gst == G_MODE_SETTING) begin
      next_illegal = clkEn && !(cmd == CMD_DESELECT || cmd == CMD_NOP);
    end else if (gst == G_SELF_REFRESH) begin
      next_illegal = clkEn && !(cmd == CMD_DESELECT || cmd == CMD_NOP);
    end else if (cmdPhase) begin
      next_illegal = bankBad || ((cmd == CMD_REFRESH || cmd == CMD_MODE_SET) && !allIdle);
      if (cmd == CMD_MODE_SET && bankSel[1]) begin
        next_illegal = 1'b1;
      end
    end else if (gst == G_NORMAL && clkEnPrev && !clkEn && allIdle) begin
      next_illegal = !(cmd inside {CMD_DESELECT, CMD_NOP, CMD_REFRESH});
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      illegalCmd <= 1'b0;
    end else begin
      illegalCmd <= next_illegal;
    end
  end

  // Per-bank state records
  for (genvar b = 0; b < BANKS; b++) begin : gBank
    logic hit, take;
    assign hit  = cmdPhase && bankSel == 2'(b);
    // No-ops and ignored closes to this bank must leave its timer running to the end
    assign take = hit && !bankBad && (cmd inside {CMD_READ, CMD_WRITE, CMD_STOP} ||
                  (cmd == CMD_ROW_OPEN && st[b] == B_IDLE) ||
                  (cmd == CMD_CLOSE && !(st[b] inside {B_IDLE, B_CLOSING})));
    always_ff @(posedge mclk) begin
      if (!reset_n) begin
        st[b]  <= B_IDLE;
        cnt[b] <= 8'h00;
      end else if (cmdPhase && cmd == CMD_CLOSE && autoClose &&
                   st[b] inside {B_ACTIVE, B_READ, B_WRITE}) begin
        st[b]  <= B_CLOSING;
        cnt[b] <= 8'(CLOSE_CYC);
      end else if (gst == G_SUSPEND) begin
        st[b] <= st[b];
      end else if (take) begin
        unique case (cmd)
          CMD_ROW_OPEN: if (st[b] == B_IDLE) begin
            st[b]  <= B_OPENING;
            cnt[b] <= 8'(RCD_CYC);
          end
          CMD_READ: begin
            st[b]  <= autoClose ? B_READ_AC : B_READ;
            cnt[b] <= 8'(BURST);
          end
          CMD_WRITE: begin
            st[b]  <= autoClose ? B_WRITE_AC : B_WRITE;
            cnt[b] <= 8'(BURST);
          end
          CMD_STOP: st[b] <= B_ACTIVE;
          CMD_CLOSE: if (st[b] != B_IDLE && st[b] != B_CLOSING) begin
            st[b]  <= B_CLOSING;
            cnt[b] <= 8'(CLOSE_CYC);
          end
          default: st[b] <= st[b];
        endcase
      end else if (cnt[b] > 8'h01) begin
        cnt[b] <= cnt[b] - 8'h01;
      end else if (cnt[b] == 8'h01) begin
        cnt[b] <= 8'h00;
        unique case (st[b])
          B_OPENING:  st[b] <= B_ACTIVE;
          B_READ:     st[b] <= B_ACTIVE;
          B_WRITE:    st[b] <= B_ACTIVE;
          B_READ_AC: begin
            st[b]  <= B_CLOSING;
            cnt[b] <= 8'(CLOSE_CYC);
          end
          B_WRITE_AC: begin
            st[b]  <= B_RECOVER;
            cnt[b] <= 8'(RECOV_CYC);
          end
          B_RECOVER: begin
            st[b]  <= B_CLOSING;
            cnt[b] <= 8'(CLOSE_CYC);
          end
          B_CLOSING:  st[b] <= B_IDLE;
          default:    st[b] <= st[b];
        endcase
      end
    end
    always_ff @(posedge mclk) begin
      if (!reset_n) begin
        row_addr[b*ROW_W +: ROW_W] <= '0;
        col_addr[b*COL_W +: COL_W] <= '0;
      end else if (hit && !bankBad && cmd == CMD_ROW_OPEN && st[b] == B_IDLE) begin
        row_addr[b*ROW_W +: ROW_W] <= addr;
      end else if (hit && !bankBad && (cmd == CMD_READ || cmd == CMD_WRITE)) begin
        col_addr[b*COL_W +: COL_W] <= addr[COL_W-1:0];
      end
    end
    assign bankState[b*4 +: 4] = st[b];
  end

  // Global modes: refresh, mode set, power modes, suspend
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      gst  <= G_NORMAL;
      gcnt <= 8'h00;
    end else begin
      unique case (gst)
        G_NORMAL: if (clkEnPrev && !clkEn) begin
          if (allIdle && cmd == CMD_REFRESH) begin
            gst <= G_SELF_REFRESH;
          end else if (allIdle && (cmd == CMD_DESELECT || cmd == CMD_NOP)) begin
            gst <= G_POWER_DOWN;
          end else if (!allIdle) begin
            gst <= G_SUSPEND;
          end
        end else if (cmdPhase && allIdle && cmd == CMD_REFRESH) begin
          gst  <= G_REFRESHING;
          gcnt <= 8'(RC_CYC);
        end else if (cmdPhase && allIdle && cmd == CMD_MODE_SET && !bankSel[1]) begin
          gst  <= G_MODE_SETTING;
          gcnt <= 8'(MRS_CYC);
        end
        G_REFRESHING, G_MODE_SETTING, G_SR_EXIT: if (gcnt <= 8'h01) begin
          gst <= G_NORMAL;
          gcnt <= 8'h00;
        end else begin
          gcnt <= gcnt - 8'h01;
        end
        G_SELF_REFRESH: if (clkEn && (cmd == CMD_DESELECT || cmd == CMD_NOP)) begin
          gst  <= G_SR_EXIT;
          gcnt <= 8'(RC_CYC);
        end
        G_POWER_DOWN: if (clkEn) begin
          gst <= G_NORMAL;
        end
        G_SUSPEND: if (clkEn) begin
          gst <= G_NORMAL;
        end
      endcase
    end
  end
  assign globalState = gst;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      baseMode <= MODE_RESET;
      extMode  <= MODE_RESET;
    end else if (cmdPhase && allIdle && cmd == CMD_MODE_SET) begin
      if (bankSel == MODE_BASE_SEL) begin
        baseMode <= addr;
      end else if (bankSel == MODE_EXT_SEL) begin
        extMode <= addr;
      end
    end
  end

  // Event word per command in the command phase other than no-op or deselect, legal or not: {bank, command};
  // a push into a full buffer with no pop that cycle counts as overrun
  logic [7:0] buf0, buf1;
  logic [1:0] fill;
  logic pushEv, popEv;
  assign pushEv = cmdPhase && !(cmd == CMD_DESELECT || cmd == CMD_NOP);
  assign popEv  = evtValid && evtReady;
  assign evtValid = fill != 2'h0;
  assign evtData  = buf0;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      fill <= 2'h0;
      buf0 <= 8'h00;
      buf1 <= 8'h00;
      evtOverrun <= 1'b0;
    end else begin
      evtOverrun <= pushEv && fill == 2'h2 && !popEv;
      if (popEv) begin
        buf0 <= (pushEv && fill == 2'h1) ? {2'h0, bankSel, cmd} : buf1;
        buf1 <= {2'h0, bankSel, cmd};
        fill <= (pushEv) ? fill : fill - 2'h1;
      end else if (pushEv && fill != 2'h2) begin
        if (fill == 2'h0) begin
          buf0 <= {2'h0, bankSel, cmd};
        end else begin
          buf1 <= {2'h0, bankSel, cmd};
        end
        fill <= fill + 2'h1;
      end
    end
  end

  // Checks
  open_latch_a: assert property (@(posedge mclk) disable iff (!reset_n)
    cmdPhase && cmd == CMD_ROW_OPEN && st[bankSel] == B_IDLE |=> st[$past(bankSel)] == B_OPENING)
    else $error("row open did not start opening");
  mode_base_a: assert property (@(posedge mclk) disable iff (!reset_n)
    cmdPhase && allIdle && cmd == CMD_MODE_SET && bankSel == 2'h0 |=> baseMode == $past(addr))
    else $error("base mode not written");
  refresh_go_a: assert property (@(posedge mclk) disable iff (!reset_n)
    cmdPhase && allIdle && cmd == CMD_REFRESH && clkEn |=> gst == G_REFRESHING)
    else $error("refresh not entered");
  sr_enter_a: assert property (@(posedge mclk) disable iff (!reset_n)
    gst == G_NORMAL && clkEnPrev && !clkEn && allIdle && cmd == CMD_REFRESH |=> gst == G_SELF_REFRESH)
    else $error("self refresh not entered");
  suspend_a: assert property (@(posedge mclk) disable iff (!reset_n)
    gst == G_NORMAL && clkEnPrev && !clkEn && !allIdle |=> gst == G_SUSPEND)
    else $error("suspend not entered");
  pd_exit_a: assert property (@(posedge mclk) disable iff (!reset_n)
    gst == G_POWER_DOWN && clkEn |=> gst == G_NORMAL)
    else $error("power down exit failed");
  illegal_mrs_a: assert property (@(posedge mclk) disable iff (!reset_n)
    gst == G_MODE_SETTING && clkEn && !(cmd inside {CMD_DESELECT, CMD_NOP}) |=> illegalCmd)
    else $error("command in mode recovery not flagged");
  close_idle_a: assert property (@(posedge mclk) disable iff (!reset_n)
    cmdPhase && cmd == CMD_CLOSE && !autoClose && st[bankSel] == B_IDLE |=> st[$past(bankSel)] == B_IDLE)
    else $error("close disturbed idle bank");
  cover_read_c: cover property (@(posedge mclk) cmdPhase && cmd == CMD_READ && !bankBad);
  cover_sr_c: cover property (@(posedge mclk) gst == G_SR_EXIT);
  cover_full_c: cover property (@(posedge mclk) fill == 2'h2);
endmodule
`default_nettype wire

// file: test/evt_sink.sv
// Event consumer on the far side of the stream: stalls one cycle in four, or fully on request
`timescale 1ns/1ps
`default_nettype none
module evt_sink (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset_n,
  // Stream control
  input  wire logic stall,
  output logic      evtReady
);
  logic [1:0] phase;

  // Periodic stall keeps the buffer working without ever filling it by accident
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      phase    <= 2'h0;
      evtReady <= 1'b0;
    end else begin
      phase    <= phase + 2'h1;
      evtReady <= !stall && (phase != 2'h3);
    end
  end
endmodule
`default_nettype wire

// file: test/tb_ddr_bank_command_fsm.sv
// Self-checking bench for the bank command state logic
`timescale 1ns/1ps
`default_nettype none
module tb_ddr_bank_command_fsm
  import bank_cmd_pkg::*;
;
  localparam logic [3:0] P_NOP = 4'h7, P_ACT = 4'h3, P_RD = 4'h5, P_WR = 4'h4;
  localparam logic [3:0] P_PRE = 4'h2, P_REF = 4'h1, P_MRS = 4'h0, P_STOP = 4'h6;
  logic                   mclk = 1'b0, reset_n = 1'b0, clkEn = 1'b1, stall = 1'b0;
  logic                   chipSel_n = 1'b1, rowStrobe_n = 1'b1, colStrobe_n = 1'b1, writeEn_n = 1'b1;
  logic [1:0]             bankSel = 2'h0;
  logic [ROW_W-1:0]       addr = 13'h0000, r, bm, em;
  logic [4*NUM_BANKS-1:0] bankState;
  logic [ROW_W*NUM_BANKS-1:0] row_addr;
  logic [COL_W*NUM_BANKS-1:0] col_addr;
  logic [ROW_W-1:0]       baseMode, extMode;
  logic [2:0]             globalState;
  logic                   illegalCmd, evtValid, evtReady, evtOverrun, sawOvr = 1'b0;
  logic [7:0]             evtData;
  logic [7:0]             evtQ[$];
  int                     miscompares = 0, cmpCount = 0, illCount = 0, ill0;

  always #4 mclk = ~mclk;

  ddr_bank_command_fsm i_ddr_bank_command_fsm (.mclk(mclk), .reset_n(reset_n), .clkEn(clkEn),
    .chipSel_n(chipSel_n), .rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n), .writeEn_n(writeEn_n),
    .bankSel(bankSel), .addr(addr), .bankState(bankState), .row_addr(row_addr), .col_addr(col_addr),
    .baseMode(baseMode), .extMode(extMode), .globalState(globalState), .illegalCmd(illegalCmd),
    .evtValid(evtValid), .evtReady(evtReady), .evtData(evtData), .evtOverrun(evtOverrun));
  evt_sink i_evt_sink (.mclk(mclk), .reset_n(reset_n), .stall(stall), .evtReady(evtReady));

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmpCount++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask

  function automatic logic [15:0] st(input int b);
    return {12'h000, bankState[4*b +: 4]};
  endfunction

  // Command held one cycle, then no-op; returns just after the edge that took it
  task automatic cmd(input logic [3:0] p, input cmd_t c, input logic [1:0] b, input logic [ROW_W-1:0] a,
                     input bit ev = 1'b1);
    @(posedge mclk);
    {chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n} <= p;
    bankSel <= b;
    addr    <= a;
    if (ev) evtQ.push_back({2'h0, b, c});
    @(posedge mclk);
    {chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n} <= P_NOP;
    #1;
  endtask

  task automatic waitN(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic print_verdict;
    $display("Counts: %0d comparisons, %0d mismatches", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Scoreboard: every accepted event must match the oldest note
  always @(posedge mclk) begin
    if (illegalCmd === 1'b1) illCount++;
    if (evtOverrun === 1'b1) sawOvr = 1'b1;
    if (reset_n && evtValid === 1'b1 && evtReady === 1'b1) begin
      if (evtQ.size() == 0) chk("spare event", 16'h0, {8'h0, evtData});
      else chk("event", {8'h0, evtQ.pop_front()}, {8'h0, evtData});
    end
  end

  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    print_verdict();
  end

  initial begin
    void'($urandom(5));
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    waitN(1);
    chk("reset banks", 16'h0, bankState);
    chk("reset global", 16'h0, {13'h0, globalState});
    $display("done reset");
    r = 13'($urandom);
    cmd(P_ACT, CMD_ROW_OPEN, 2'h1, r);
    chk("opening", B_OPENING, st(1));
    chk("row", r, row_addr[ROW_W +: ROW_W]);
    chk("other bank", B_IDLE, st(0));
    waitN(2);
    chk("still opening", B_OPENING, st(1));
    waitN(1);
    chk("active", B_ACTIVE, st(1));
    ill0 = illCount;
    cmd(P_ACT, CMD_ROW_OPEN, 2'h2, 13'h0000);
    cmd(P_RD, CMD_READ, 2'h2, 13'h0000);
    r = {3'h0, 10'($urandom)};
    cmd(P_RD, CMD_READ, 2'h1, r);
    chk("read", B_READ, st(1));
    chk("col", r, {3'h0, col_addr[COL_W +: COL_W]});
    waitN(2);
    chk("illegal read", ill0 + 1, illCount);
    $display("done open");
    r = {3'h0, 10'($urandom)};
    cmd(P_RD, CMD_READ, 2'h1, r);
    chk("reread col", r, {3'h0, col_addr[COL_W +: COL_W]});
    waitN(2);
    chk("burst runs", B_READ, st(1));
    cmd(P_STOP, CMD_STOP, 2'h1, 13'h0000);
    chk("stopped", B_ACTIVE, st(1));
    cmd(P_WR, CMD_WRITE, 2'h1, 13'h0011);
    chk("write", B_WRITE, st(1));
    cmd(P_WR, CMD_WRITE, 2'h1, 13'h0022);
    chk("rewrite col", 16'h0022, {6'h0, col_addr[COL_W +: COL_W]});
    cmd(P_RD, CMD_READ, 2'h1, 13'h0033);
    chk("read after write", B_READ, st(1));
    waitN(12);
    chk("burst end", B_ACTIVE, st(1));
    cmd(P_WR, CMD_WRITE, 2'h1, 13'h0400);
    chk("write autoclose", B_WRITE_AC, st(1));
    cmd(P_RD, CMD_READ, 2'h2, 13'h0405);
    chk("read autoclose", B_READ_AC, st(2));
    waitN(20);
    chk("closed after write", B_IDLE, st(1));
    chk("closed after read", B_IDLE, st(2));
    $display("done bursts");
    cmd(P_ACT, CMD_ROW_OPEN, 2'h3, 13'h0001);
    waitN(4);
    ill0 = illCount;
    cmd(P_PRE, CMD_CLOSE, 2'h3, 13'h0000);
    chk("closing", B_CLOSING, st(3));
    cmd(P_PRE, CMD_CLOSE, 2'h0, 13'h0000);
    chk("close idle", B_IDLE, st(0));
    chk("still closing", B_CLOSING, st(3));
    waitN(1);
    chk("closed", B_IDLE, st(3));
    chk("no illegal", ill0, illCount);
    $display("done close");
    ill0 = illCount;
    cmd(P_REF, CMD_REFRESH, 2'h0, 13'h0000);
    chk("refreshing", G_REFRESHING, globalState);
    cmd(P_ACT, CMD_ROW_OPEN, 2'h0, 13'h0000, 1'b0);
    waitN(9);
    chk("refresh end", G_NORMAL, globalState);
    chk("refresh illegal", ill0 + 1, illCount);
    chk("act ignored", B_IDLE, st(0));
    bm = baseMode;
    em = extMode;
    for (int b = 0; b < 4; b++) begin
      ill0 = illCount;
      r = 13'($urandom);
      cmd(P_MRS, CMD_MODE_SET, 2'(b), r);
      if (b == 0) bm = r;
      if (b == 1) em = r;
      waitN(4);
      chk("base mode", bm, baseMode);
      chk("ext mode", em, extMode);
      chk("mode illegal", ill0 + (b > 1), illCount);
    end
    ill0 = illCount;
    cmd(P_MRS, CMD_MODE_SET, 2'h0, 13'h0000);
    cmd(P_ACT, CMD_ROW_OPEN, 2'h0, 13'h0000, 1'b0);
    waitN(3);
    chk("mode recovery", ill0 + 1, illCount);
    $display("done modes");
    @(posedge mclk);
    clkEn <= 1'b0;
    waitN(2);
    chk("power down", G_POWER_DOWN, globalState);
    @(posedge mclk);
    clkEn <= 1'b1;
    waitN(2);
    chk("power up", G_NORMAL, globalState);
    @(posedge mclk);
    clkEn <= 1'b0;
    {chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n} <= P_REF;
    @(posedge mclk);
    {chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n} <= P_NOP;
    waitN(6);
    chk("self refresh", G_SELF_REFRESH, globalState);
    @(posedge mclk);
    clkEn <= 1'b1;
    waitN(2);
    chk("exit", G_SR_EXIT, globalState);
    waitN(12);
    chk("exit done", G_NORMAL, globalState);
    cmd(P_ACT, CMD_ROW_OPEN, 2'h1, 13'h0005);
    waitN(4);
    @(posedge mclk);
    clkEn <= 1'b0;
    waitN(2);
    chk("suspend", G_SUSPEND, globalState);
    @(posedge mclk);
    {chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n} <= P_PRE;
    @(posedge mclk);
    {chipSel_n, rowStrobe_n, colStrobe_n, writeEn_n} <= P_NOP;
    clkEn <= 1'b1;
    waitN(3);
    chk("resume", G_NORMAL, globalState);
    chk("frozen bank", B_ACTIVE, st(1));
    $display("done clock enable");
    stall <= 1'b1;
    cmd(P_ACT, CMD_ROW_OPEN, 2'h0, 13'h0000);
    cmd(P_ACT, CMD_ROW_OPEN, 2'h2, 13'h0000);
    cmd(P_ACT, CMD_ROW_OPEN, 2'h3, 13'h0000, 1'b0);
    waitN(4);
    chk("overrun", 16'h1, {15'h0, sawOvr});
    chk("dropped event kept cmd", B_ACTIVE, st(3));
    stall <= 1'b0;
    waitN(10);
    cmd(P_PRE, CMD_CLOSE, 2'h0, 13'h0400);
    waitN(6);
    chk("all closed", 16'h0, bankState);
    chk("events drained", 16'h0, 16'(evtQ.size()));
    $display("done stream");
    print_verdict();
  end
endmodule
`default_nettype wire
